// ==== logic/ext_irq_pkg.sv ====
/*
 * constants for the external interrupt sense block: special function
 * register addresses, field positions and reset values.
 * assumes an 8-bit special function register bus inside the core.
 */
package ext_irq_pkg;
	// pin and polarity configuration register
	localparam logic [7:0] CFG_ADDR = 8'hE4;
	localparam logic [7:0] CFG_RESET = 8'h01;
	localparam int CFG_FIRST_SEL_LSB = 0; // bits 2:0
	localparam int CFG_FIRST_POL_BIT = 3;
	localparam int CFG_SECOND_SEL_LSB = 4; // bits 6:4
	localparam int CFG_SECOND_POL_BIT = 7;
	localparam int SEL_W = 3;
	// timer control register, low nibble owned here
	localparam int TCTL_FIRST_EDGE_BIT = 0;
	localparam int TCTL_FIRST_PEND_BIT = 1;
	localparam int TCTL_SECOND_EDGE_BIT = 2;
	localparam int TCTL_SECOND_PEND_BIT = 3;
	// interrupt priority register bits
	localparam int PRIO_FIRST_BIT = 0;
	localparam int PRIO_SECOND_BIT = 2;
	localparam int NUM_IRQ = 2;
	localparam int PORT_W = 8;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// ==== logic/irq_sense.sv ====
/*
 * one external interrupt channel: pin selection, polarity, edge or level
 * sensing and the pending flag.
 * assumes the port vector is already synchronised to i_clk.
 */
`timescale 1ns/1ps
module irq_sense
	import ext_irq_pkg::*;
#(
	parameter int PW = PORT_W
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [PW-1:0] i_port_sync,
	input wire logic [SEL_W-1:0] i_sel,
	input wire logic i_polarity,
	input wire logic i_edge,
	input wire logic i_vector_clr,
	input wire logic i_sw_wr,
	input wire logic i_sw_val,
	output logic o_pending
);
	// refuse a port that the three-bit select does not cover exactly
	if (PW != (1 << SEL_W)) begin : g_port
		$error("port width must match select range");
	end

	logic prev_active;
	logic next_pending;
	wire logic pin = i_port_sync[i_sel];
	// active when the pin equals the polarity bit
	wire logic active = ~(pin ^ i_polarity);
	wire logic rise = active & ~prev_active;

	// edge: set wins over vector clear and software write; level: follows input
	always_comb begin
		if (!i_edge) begin
			next_pending = active;
		end else if (rise) begin
			next_pending = 1'b1;
		end else if (i_vector_clr) begin
			next_pending = 1'b0;
		end else if (i_sw_wr) begin
			next_pending = i_sw_val;
		end else begin
			next_pending = o_pending;
		end
	end

	// pending flag and previous active level
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pending <= 1'b0;
			prev_active <= 1'b0;
		end else begin
			o_pending <= next_pending;
			prev_active <= active;
		end
	end

	a_level_tracks: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_edge ##1 !i_edge |-> o_pending == $past(active))
		else $error("level pending does not follow input");
	a_edge_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_edge && rise |=> o_pending)
		else $error("edge did not set pending");
	a_vector_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_edge && i_vector_clr && !rise |=> !o_pending)
		else $error("vectoring did not clear pending");
	a_edge_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_edge && o_pending && !i_vector_clr && !i_sw_wr ##1 i_edge |-> o_pending)
		else $error("edge pending dropped on its own");
	c_edge_event: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		i_edge && rise ##[1:4] i_vector_clr);
	c_level_event: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_edge && active ##1 !active);
endmodule // irq_sense

// ==== logic/ext_irq_top.sv ====
/*
 * external interrupt sense block: two interrupt inputs taken from
 * selectable port 0 pins, with polarity, edge or level sensing, pending
 * flags, priority bits and the pin dedication mask for the crossbar.
 * assumes an 8-bit special function register bus on the system clock
 * and one-cycle vector acknowledge pulses from the interrupt logic.
 */
// Function
// - each input has a polarity bit, 0 active low and 1 active high.
// - each input has a sense bit, 1 edge and 0 level sensitive.
// - bits 6:4 select which port 0 pin feeds the second input.
// - bits 2:0 select which port 0 pin feeds the first input.
// - inputs sample their pins without driving or disturbing them.
// - a skipped selected pin is left dedicated to the interrupt input.
// - pending flags sit in bits 1 and 3 of the timer control register.
// - in edge mode the pending flag clears when the cpu vectors.
// - in level mode the pending flag equals the active state of the input.
// - each input has a priority bit, 0 low and 1 high.
`timescale 1ns/1ps
module ext_irq_top
	import ext_irq_pkg::*;
#(
	parameter logic [7:0] TCTL_ADDR = 8'h88,
	parameter logic [7:0] PRIO_ADDR = 8'hB8
) (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic [PORT_W-1:0] i_PORT0,
	input wire logic [7:0] i_SFR_ADDR,
	input wire logic [7:0] i_SFR_WDATA,
	input wire logic i_SFR_WR,
	input wire logic [NUM_IRQ-1:0] i_VECTOR_ACK,
	input wire logic [PORT_W-1:0] i_CROSSBAR_SKIP,
	output logic [7:0] o_SFR_RDATA,
	output logic [NUM_IRQ-1:0] o_IRQ_PENDING,
	output logic [NUM_IRQ-1:0] o_IRQ_PRIORITY,
	output logic [PORT_W-1:0] o_PIN_DEDICATED
);
	logic [PORT_W-1:0] sync_a;
	logic [PORT_W-1:0] sync_b;
	logic [7:0] cfg;
	logic [NUM_IRQ-1:0] edge_sel;
	logic [NUM_IRQ-1:0] pending;
	logic [7:0] next_rdata;

	// two-stage synchroniser on every port pin, pins are only read
	// the stages clear to zero, so for two edges after reset every pin reads low
	// and an active-low level input shows pending until real pin levels arrive
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= i_PORT0;
			sync_b <= sync_a;
		end
	end

	// refuse address maps that would alias two registers onto one address
	if (TCTL_ADDR == CFG_ADDR || PRIO_ADDR == CFG_ADDR || TCTL_ADDR == PRIO_ADDR) begin : g_map
		$error("register addresses must be distinct");
	end
	// refuse a port that the three-bit selects do not cover exactly
	if (PORT_W != (1 << SEL_W)) begin : g_port
		$error("port width must match select range");
	end
	// the channel wiring below is written out for exactly two inputs
	if (NUM_IRQ != 2) begin : g_count
		$error("exactly two interrupt inputs are supported");
	end

	// register decode
	wire logic wr_cfg = i_SFR_WR && (i_SFR_ADDR == CFG_ADDR);
	wire logic wr_tctl = i_SFR_WR && (i_SFR_ADDR == TCTL_ADDR);
	wire logic wr_prio = i_SFR_WR && (i_SFR_ADDR == PRIO_ADDR);

	// configuration, sense select and priority registers
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cfg <= CFG_RESET;
			edge_sel <= '0;
			o_IRQ_PRIORITY <= '0;
		end else begin
			if (wr_cfg) cfg <= i_SFR_WDATA;
			if (wr_tctl) begin
				edge_sel[0] <= i_SFR_WDATA[TCTL_FIRST_EDGE_BIT];
				edge_sel[1] <= i_SFR_WDATA[TCTL_SECOND_EDGE_BIT];
			end
			if (wr_prio) begin
				o_IRQ_PRIORITY[0] <= i_SFR_WDATA[PRIO_FIRST_BIT];
				o_IRQ_PRIORITY[1] <= i_SFR_WDATA[PRIO_SECOND_BIT];
			end
		end
	end

	// per-channel configuration fields
	wire logic [SEL_W-1:0] sel [NUM_IRQ];
	wire logic pol [NUM_IRQ];
	wire logic sw_val [NUM_IRQ];
	assign sel[0] = cfg[CFG_FIRST_SEL_LSB +: SEL_W];
	assign sel[1] = cfg[CFG_SECOND_SEL_LSB +: SEL_W];
	assign pol[0] = cfg[CFG_FIRST_POL_BIT];
	assign pol[1] = cfg[CFG_SECOND_POL_BIT];
	assign sw_val[0] = i_SFR_WDATA[TCTL_FIRST_PEND_BIT];
	assign sw_val[1] = i_SFR_WDATA[TCTL_SECOND_PEND_BIT];

	// one sense channel per external interrupt
	genvar g;
	generate
		for (g = 0; g < NUM_IRQ; g++) begin : gen_ch
			irq_sense #(.PW(PORT_W)) u_sense (
				.i_clk(I_CLK),
				.i_rst_n(I_RST_N),
				.i_port_sync(sync_b),
				.i_sel(sel[g]),
				.i_polarity(pol[g]),
				.i_edge(edge_sel[g]),
				.i_vector_clr(i_VECTOR_ACK[g]),
				.i_sw_wr(wr_tctl),
				.i_sw_val(sw_val[g]),
				.o_pending(pending[g])
			);
		end
	endgenerate
	assign o_IRQ_PENDING = pending;

	// selected pins that the crossbar skips stay dedicated to the inputs
	wire logic [PORT_W-1:0] sel_mask = (PORT_W'(1) << sel[0]) | (PORT_W'(1) << sel[1]);
	assign o_PIN_DEDICATED = sel_mask & i_CROSSBAR_SKIP;

	// read data mux, unmapped addresses read zero
	wire logic [7:0] tctl_rd = {4'h0, pending[1], edge_sel[1], pending[0], edge_sel[0]};
	wire logic [7:0] prio_rd = {5'h00, o_IRQ_PRIORITY[1], 1'b0, o_IRQ_PRIORITY[0]};
	always_comb begin
		next_rdata = BYTE_ZERO;
		if (i_SFR_ADDR == CFG_ADDR) next_rdata = cfg;
		else if (i_SFR_ADDR == TCTL_ADDR) next_rdata = tctl_rd;
		else if (i_SFR_ADDR == PRIO_ADDR) next_rdata = prio_rd;
	end

	// registered read data
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) o_SFR_RDATA <= BYTE_ZERO;
		else o_SFR_RDATA <= next_rdata;
	end

	a_sync_delay: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		##2 1'b1 |-> sync_b == $past(i_PORT0, 2))
		else $error("synchroniser latency is not two cycles");
	a_cfg_write: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		wr_cfg |=> cfg == $past(i_SFR_WDATA))
		else $error("configuration write lost");
	a_pend_readback: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		i_SFR_ADDR == TCTL_ADDR |=> o_SFR_RDATA[TCTL_SECOND_PEND_BIT] == $past(pending[1])
			&& o_SFR_RDATA[TCTL_FIRST_PEND_BIT] == $past(pending[0]))
		else $error("pending flags not at bits 1 and 3");
	a_prio_write: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		wr_prio |=> o_IRQ_PRIORITY[1] == $past(i_SFR_WDATA[PRIO_SECOND_BIT]))
		else $error("priority write lost");
	a_pin_dedicated: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		i_CROSSBAR_SKIP[sel[0]] |-> o_PIN_DEDICATED[sel[0]])
		else $error("skipped selected pin not dedicated");
	a_level_first: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!edge_sel[0] ##1 !edge_sel[0] && $stable(cfg) |->
			pending[0] == ($past(sync_b[sel[0]]) == cfg[CFG_FIRST_POL_BIT]))
		else $error("first input level not from selected pin");

	// second input: pin select, polarity, level tracking and dedication
	a_level_second: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!edge_sel[1] ##1 !edge_sel[1] && $stable(cfg) |->
			pending[1] == ($past(sync_b[sel[1]]) == cfg[CFG_SECOND_POL_BIT]))
		else $error("second input level not from selected pin");
	a_ded_second: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		i_CROSSBAR_SKIP[sel[1]] |-> o_PIN_DEDICATED[sel[1]])
		else $error("skipped second pin not dedicated");

	// sense select bits: taken from the timer control write, read back, held otherwise
	a_tctl_write: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		wr_tctl |=> edge_sel[0] == $past(i_SFR_WDATA[TCTL_FIRST_EDGE_BIT])
			&& edge_sel[1] == $past(i_SFR_WDATA[TCTL_SECOND_EDGE_BIT]))
		else $error("sense select write lost");
	a_tctl_edge_bits: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		i_SFR_ADDR == TCTL_ADDR |=> o_SFR_RDATA[TCTL_FIRST_EDGE_BIT] == $past(edge_sel[0])
			&& o_SFR_RDATA[TCTL_SECOND_EDGE_BIT] == $past(edge_sel[1]))
		else $error("sense select bits not at bits 0 and 2");
	a_edge_bits_hold: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!wr_tctl |=> $stable(edge_sel))
		else $error("sense select changed without a write");

	// configuration register read back and held between writes
	a_cfg_readback: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		i_SFR_ADDR == CFG_ADDR |=> o_SFR_RDATA == $past(cfg))
		else $error("configuration read back wrong");
	a_cfg_hold: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!wr_cfg |=> $stable(cfg))
		else $error("configuration changed without a write");

	// priority bits: written, read back at bits 0 and 2, held otherwise
	a_prio_first: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		wr_prio |=> o_IRQ_PRIORITY[0] == $past(i_SFR_WDATA[PRIO_FIRST_BIT]))
		else $error("first priority write lost");
	a_prio_readback: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		i_SFR_ADDR == PRIO_ADDR |=> o_SFR_RDATA[PRIO_FIRST_BIT] == $past(o_IRQ_PRIORITY[0])
			&& o_SFR_RDATA[PRIO_SECOND_BIT] == $past(o_IRQ_PRIORITY[1]))
		else $error("priority bits not at bits 0 and 2");
	a_prio_hold: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!wr_prio |=> $stable(o_IRQ_PRIORITY))
		else $error("priority changed without a write");

	// dedication never reaches a pin the crossbar still owns, nor a third pin
	a_ded_needs_skip: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(o_PIN_DEDICATED & ~i_CROSSBAR_SKIP) == '0)
		else $error("pin dedicated without a crossbar skip");
	a_ded_at_most_two: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		$countones(o_PIN_DEDICATED) <= NUM_IRQ)
		else $error("more pins dedicated than inputs");

	// main scenarios
	c_cfg_write: cover property (@(posedge I_CLK) disable iff (!I_RST_N) wr_cfg);
	c_both_pending: cover property (@(posedge I_CLK) disable iff (!I_RST_N) &pending);
	c_edge_pending: cover property (@(posedge I_CLK) disable iff (!I_RST_N) &edge_sel && |pending);
endmodule // ext_irq_top

// ==== verification/irq_source.sv ====
/*
 * far-side model: one external source driving a port 0 pin.
 * assumes the bench starts a request with a one-cycle go pulse.
 */
`timescale 1ns/1ps
module irq_source (
	input wire logic i_clk,
	input wire logic [2:0] i_pin,
	input wire logic i_active,
	input wire logic i_go,
	input wire logic i_seen,
	output logic [7:0] o_pins
);
	logic held = 1'b0;
	// request held until the pending flag shows, then withdrawn
	always_ff @(posedge i_clk) begin
		if (i_go) begin
			held <= 1'b1;
		end else if (i_seen) begin
			held <= 1'b0;
		end
	end
	// idle pins sit at the inactive level
	assign o_pins = {8{~i_active}} ^ (held ? (8'h01 << i_pin) : 8'h00);
endmodule // irq_source

// ==== verification/external_interrupt_sense_tb.sv ====
/*
 * self-checking bench for the external interrupt sense block.
 * assumes the default timer control and priority addresses.
 */
`timescale 1ns/1ps
module external_interrupt_sense_tb;
	import ext_irq_pkg::*;
	localparam logic [7:0] TCTL_A = 8'h88;
	localparam logic [7:0] PRIO_A = 8'hB8;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, go = 1'b0, act = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, skip = 8'hA5, pins, rdata, ded;
	logic [2:0] psel = 3'h0;
	logic [1:0] ack = 2'h0, pend, prio;
	int err_total = 0, total_checks = 0;
	// 25 MHz clock
	always #20 clk = ~clk;
	irq_source u_src (.i_clk(clk), .i_pin(psel), .i_active(act), .i_go(go),
		.i_seen(|pend), .o_pins(pins));
	ext_irq_top #(.TCTL_ADDR(TCTL_A), .PRIO_ADDR(PRIO_A)) u_dut (.I_CLK(clk),
		.I_RST_N(rst_n), .i_PORT0(pins), .i_SFR_ADDR(addr), .i_SFR_WDATA(wdata),
		.i_SFR_WR(wr), .i_VECTOR_ACK(ack), .i_CROSSBAR_SKIP(skip),
		.o_SFR_RDATA(rdata), .o_IRQ_PENDING(pend), .o_IRQ_PRIORITY(prio),
		.o_PIN_DEDICATED(ded));
	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		addr = a;
		@(negedge clk);
		chk(rdata, exp);
	endtask
	task automatic wait_pend(input int ch, input logic v);
		int n;
		for (n = 0; n < 12 && pend[ch] !== v; n++) begin
			@(negedge clk);
		end
		chk({7'h00, pend[ch]}, {7'h00, v});
		if (n == 12) begin
			final_report();
		end
	endtask
	task automatic pulse(input logic [1:0] a);
		@(negedge clk);
		go = (a == 2'h0);
		ack = a;
		@(negedge clk);
		go = 1'b0;
		ack = 2'h0;
	endtask
	// reset values, unmapped space ignored
	task automatic t_reset();
		rd_chk(CFG_ADDR, CFG_RESET);
		rd_chk(TCTL_A, 8'h00);
		rd_chk(PRIO_A, 8'h00);
		wr_reg(8'h00, 8'hFF);
		rd_chk(8'h00, 8'h00);
		rd_chk(CFG_ADDR, CFG_RESET);
	endtask
	// level mode over every pin code and both polarities
	task automatic t_level();
		for (int s = 0; s < 8; s++) begin
			for (int p = 0; p < 2; p++) begin
				wr_reg(CFG_ADDR, {p[0], s[2:0], p[0], s[2:0]});
				psel = s[2:0];
				act = p[0];
				repeat (4) @(negedge clk);
				chk({6'h00, pend}, 8'h00);
				chk(ded, skip & (8'h01 << s));
				pulse(2'h0);
				wait_pend(0, 1'b1);
				chk({6'h00, pend}, 8'h03);
				wait_pend(0, 1'b0);
			end
		end
	endtask
	// edge mode: latch, flag bits, clear on vector
	task automatic t_edge();
		wr_reg(TCTL_A, 8'h05);
		wr_reg(CFG_ADDR, 8'hAD);
		act = 1'b1;
		repeat (4) @(negedge clk);
		wr_reg(TCTL_A, 8'h05);
		rd_chk(TCTL_A, 8'h05);
		psel = 3'h5;
		pulse(2'h0);
		wait_pend(0, 1'b1);
		repeat (6) @(negedge clk);
		chk({6'h00, pend}, 8'h01);
		rd_chk(TCTL_A, 8'h07);
		pulse(2'h1);
		wait_pend(0, 1'b0);
		wr_reg(TCTL_A, 8'h0F);
		rd_chk(TCTL_A, 8'h0F);
		wr_reg(TCTL_A, 8'h05);
		rd_chk(TCTL_A, 8'h05);
		psel = 3'h2;
		pulse(2'h0);
		wait_pend(1, 1'b1);
		rd_chk(TCTL_A, 8'h0D);
		pulse(2'h2);
		wait_pend(1, 1'b0);
	endtask
	// priority bits
	task automatic t_prio();
		wr_reg(PRIO_A, 8'hFF);
		rd_chk(PRIO_A, 8'h05);
		chk({6'h00, prio}, 8'h03);
		wr_reg(PRIO_A, 8'h04);
		chk({6'h00, prio}, 8'h02);
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_level();
		t_edge();
		t_prio();
		final_report();
	end
endmodule // external_interrupt_sense_tb
